// ### design/slr_regs.svh
`ifndef SLR_REGS_SVH
`define SLR_REGS_SVH

// Register byte addresses
`define SLR_ADDR_AMB_PARAM   8'h84
`define SLR_ADDR_AMB_HIGH    8'h85
`define SLR_ADDR_AMB_LOW     8'h86
`define SLR_ADDR_BIO_HIGH    8'h87
`define SLR_ADDR_BIO_LOW     8'h88
`define SLR_ADDR_IRQ_CTRL    8'h89
`define SLR_ADDR_LOW_THR_HI  8'h8A
`define SLR_ADDR_LOW_THR_LO  8'h8B
`define SLR_ADDR_HIGH_THR_HI 8'h8C
`define SLR_ADDR_HIGH_THR_LO 8'h8D
`define SLR_ADDR_IRQ_STATUS  8'h8E

// Interrupt control fields
`define SLR_CTRL_COUNT_MSB   7
`define SLR_CTRL_COUNT_LSB   5
`define SLR_CTRL_BIO_EN      3
`define SLR_CTRL_AMB_EN      2
`define SLR_CTRL_LIMIT_EN    1
`define SLR_CTRL_LIMIT_SEL   0

// Interrupt status fields
`define SLR_STAT_BIO_READY   3
`define SLR_STAT_AMB_READY   2
`define SLR_STAT_BELOW_LOW   1
`define SLR_STAT_ABOVE_HIGH  0

// Reset values
`define SLR_RST_CTRL         8'h00
`define SLR_RST_AMB_PARAM    8'h0D
`define SLR_RST_WORD         16'h0000
`define SLR_RST_STATUS       4'h0

`endif

// ### design/slr_pkg.sv
package slr_pkg;

	typedef struct packed {
		logic        valid;
		logic [15:0] value;
	} slr_meas_type;

	typedef struct packed {
		logic       strobe;
		logic [7:0] addr;
		logic [7:0] data;
	} slr_wr_type;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'b0000001,
		ST_ADDR  = 7'b0000010,
		ST_AACK  = 7'b0000100,
		ST_WDATA = 7'b0001000,
		ST_WACK  = 7'b0010000,
		ST_RDATA = 7'b0100000,
		ST_RACK  = 7'b1000000
	} slr_state_type;

endpackage : slr_pkg

// ### design/slr_sensor_regs.sv
`timescale 1ns/100ps
`include "slr_regs.svh"
module slr_sensor_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address
) (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 arst_n_i,
	// Serial register bus, open drain data
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe_o,
	// Measurement results from the converter
	input  wire slr_pkg::slr_meas_type amb_meas_i,
	input  wire slr_pkg::slr_meas_type bio_meas_i,
	// Self-timed measurement control
	input  wire logic                 self_timed_en_i,
	output logic [7:0]                amb_param_o,
	// Open drain interrupt pad
	output logic                      irq_pad_o,
	output logic                      irq_pad_oe_o
);

	slr_pkg::slr_state_type state;
	slr_pkg::slr_wr_type    wr;
	logic [7:0]  shift;
	logic [3:0]  bit_cnt;
	logic [7:0]  ptr;
	logic        ptr_valid;
	logic        rw;
	logic        scl_q;
	logic        sda_q;
	logic [15:0] amb_result;
	logic [15:0] bio_result;
	logic [15:0] low_thr;
	logic [15:0] high_thr;
	logic [7:0]  ctrl;
	logic [7:0]  amb_param;
	logic        self_timed_q;
	logic [3:0]  status;
	logic [3:0]  status_set;
	logic [3:0]  status_clr;
	logic [7:0]  above_cnt;
	logic [7:0]  below_cnt;
	logic [7:0]  need;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_cond;
	logic        stop_cond;
	slr_pkg::slr_meas_type src;
	logic        limit_ev;
	logic        above;
	logic        below;

	function automatic logic [7:0] count_need(input logic [2:0] code);
		count_need = 8'(9'h001 << code);
	endfunction : count_need

	function automatic logic [7:0] read_byte(input logic [7:0] a);
		case (a)
			`SLR_ADDR_AMB_PARAM:   read_byte = amb_param;
			`SLR_ADDR_AMB_HIGH:    read_byte = amb_result[15:8];
			`SLR_ADDR_AMB_LOW:     read_byte = amb_result[7:0];
			`SLR_ADDR_BIO_HIGH:    read_byte = bio_result[15:8];
			`SLR_ADDR_BIO_LOW:     read_byte = bio_result[7:0];
			`SLR_ADDR_IRQ_CTRL:    read_byte = {ctrl[7:5], 1'b0, ctrl[3:0]};
			`SLR_ADDR_LOW_THR_HI:  read_byte = low_thr[15:8];
			`SLR_ADDR_LOW_THR_LO:  read_byte = low_thr[7:0];
			`SLR_ADDR_HIGH_THR_HI: read_byte = high_thr[15:8];
			`SLR_ADDR_HIGH_THR_LO: read_byte = high_thr[7:0];
			`SLR_ADDR_IRQ_STATUS:  read_byte = {4'h0, status};
			default:               read_byte = 8'h00;
		endcase
	endfunction : read_byte

	// ****************************************************
	// Serial bus slave
	// ****************************************************
	assign scl_rise   = scl_i & ~scl_q;
	assign scl_fall   = ~scl_i & scl_q;
	assign start_cond = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_cond  = scl_i & scl_q & ~sda_q & sda_i;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	// Bytes after the pointer auto-increment on both reads and writes
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state     <= slr_pkg::ST_IDLE;
			shift     <= 8'h00;
			bit_cnt   <= 4'h0;
			ptr       <= 8'h00;
			ptr_valid <= 1'b0;
			rw        <= 1'b0;
			wr        <= '0;
		end
		else
		begin
			wr.strobe <= 1'b0;
			if (start_cond)
			begin
				state     <= slr_pkg::ST_ADDR;
				bit_cnt   <= 4'h0;
				ptr_valid <= 1'b0;
			end
			else if (stop_cond)
				state <= slr_pkg::ST_IDLE;
			else if (scl_rise)
			begin
				case (state)
					slr_pkg::ST_ADDR, slr_pkg::ST_WDATA:
					begin
						shift   <= {shift[6:0], sda_i};
						bit_cnt <= bit_cnt + 4'h1;
					end
					slr_pkg::ST_RACK:
						if (sda_i)
							state <= slr_pkg::ST_IDLE;
					default:
						state <= state;
				endcase
			end
			else if (scl_fall)
			begin
				case (state)
					slr_pkg::ST_ADDR:
						if (bit_cnt == 4'h8)
						begin
							rw    <= shift[0];
							state <= (shift[7:1] == DEV_ADDR) ?
								slr_pkg::ST_AACK : slr_pkg::ST_IDLE;
						end
					slr_pkg::ST_WDATA:
						if (bit_cnt == 4'h8)
						begin
							state <= slr_pkg::ST_WACK;
							if (!ptr_valid)
							begin
								ptr       <= shift;
								ptr_valid <= 1'b1;
							end
							else
							begin
								wr  <= '{1'b1, ptr, shift};
								ptr <= ptr + 8'h01;
							end
						end
					slr_pkg::ST_AACK, slr_pkg::ST_RACK, slr_pkg::ST_WACK:
					begin
						bit_cnt <= 4'h0;
						if (rw && state != slr_pkg::ST_WACK)
						begin
							state <= slr_pkg::ST_RDATA;
							shift <= read_byte(ptr);
							ptr   <= ptr + 8'h01;
						end
						else
							state <= slr_pkg::ST_WDATA;
					end
					slr_pkg::ST_RDATA:
						if (bit_cnt == 4'h7)
							state <= slr_pkg::ST_RACK;
						else
						begin
							shift   <= {shift[6:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
						end
					default:
						state <= state;
				endcase
			end
		end
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = (state == slr_pkg::ST_AACK)
		| (state == slr_pkg::ST_WACK)
		| ((state == slr_pkg::ST_RDATA) & ~shift[7]);

	// ****************************************************
	// Register file
	// ****************************************************
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ctrl     <= `SLR_RST_CTRL;
			low_thr  <= `SLR_RST_WORD;
			high_thr <= `SLR_RST_WORD;
		end
		else if (wr.strobe)
		begin
			case (wr.addr)
				`SLR_ADDR_IRQ_CTRL:    ctrl <= wr.data;
				`SLR_ADDR_LOW_THR_HI:  low_thr[15:8] <= wr.data;
				`SLR_ADDR_LOW_THR_LO:  low_thr[7:0] <= wr.data;
				`SLR_ADDR_HIGH_THR_HI: high_thr[15:8] <= wr.data;
				`SLR_ADDR_HIGH_THR_LO: high_thr[7:0] <= wr.data;
				default:               ctrl <= ctrl;
			endcase
		end
	end

	// Written value is held apart from the one the sequencer uses
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			amb_param    <= `SLR_RST_AMB_PARAM;
			amb_param_o  <= `SLR_RST_AMB_PARAM;
			self_timed_q <= 1'b0;
		end
		else
		begin
			self_timed_q <= self_timed_en_i;
			if (wr.strobe && wr.addr == `SLR_ADDR_AMB_PARAM)
				amb_param <= wr.data;
			if (!self_timed_en_i || !self_timed_q)
				amb_param_o <= amb_param;
		end
	end

	// Result registers only follow the converter, never the bus
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			amb_result <= `SLR_RST_WORD;
			bio_result <= `SLR_RST_WORD;
		end
		else
		begin
			if (amb_meas_i.valid)
				amb_result <= amb_meas_i.value;
			if (bio_meas_i.valid)
				bio_result <= bio_meas_i.value;
		end
	end

	// ****************************************************
	// Threshold filter and interrupt status
	// ****************************************************
	assign src      = ctrl[`SLR_CTRL_LIMIT_SEL] ? amb_meas_i : bio_meas_i;
	assign limit_ev = src.valid & ctrl[`SLR_CTRL_LIMIT_EN];
	assign above    = src.value > high_thr;
	assign below    = src.value < low_thr;
	assign need     = count_need(ctrl[`SLR_CTRL_COUNT_MSB:`SLR_CTRL_COUNT_LSB]);

	// Counters restart after each fire, so a steady excursion refires
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			above_cnt <= 8'h00;
			below_cnt <= 8'h00;
		end
		else if (!ctrl[`SLR_CTRL_LIMIT_EN])
		begin
			above_cnt <= 8'h00;
			below_cnt <= 8'h00;
		end
		else if (src.valid)
		begin
			above_cnt <= (above && status_set[0] == 1'b0) ?
				above_cnt + 8'h01 : 8'h00;
			below_cnt <= (below && status_set[1] == 1'b0) ?
				below_cnt + 8'h01 : 8'h00;
		end
	end

	always_comb
	begin
		status_set = 4'h0;
		status_set[`SLR_STAT_BIO_READY] = bio_meas_i.valid
			& ctrl[`SLR_CTRL_BIO_EN];
		status_set[`SLR_STAT_AMB_READY] = amb_meas_i.valid
			& ctrl[`SLR_CTRL_AMB_EN];
		// At or past the count, so a count lowered mid-run still fires
		status_set[`SLR_STAT_BELOW_LOW] = limit_ev & below
			& (8'(below_cnt + 8'h01) >= need);
		status_set[`SLR_STAT_ABOVE_HIGH] = limit_ev & above
			& (8'(above_cnt + 8'h01) >= need);
	end

	assign status_clr = (wr.strobe && wr.addr == `SLR_ADDR_IRQ_STATUS) ?
		wr.data[3:0] : 4'h0;

	// A new event beats a clear in the same cycle
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			status       <= `SLR_RST_STATUS;
			irq_pad_oe_o <= 1'b0;
		end
		else
		begin
			status       <= (status & ~status_clr) | status_set;
			irq_pad_oe_o <= |status;
		end
	end

	assign irq_pad_o = 1'b0;

	// ****************************************************
	// Assertions
	// ****************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence seq_running;
		// The first high cycle may still apply a value written while off
		self_timed_en_i [*3];
	endsequence

	sequence seq_bio_hit_one;
		bio_meas_i.valid && !ctrl[0] && ctrl[1] && ctrl[7:5] == 3'b000
			&& bio_meas_i.value > high_thr;
	endsequence

	sequence seq_amb_hit_one;
		amb_meas_i.valid && ctrl[0] && ctrl[1] && ctrl[7:5] == 3'b000
			&& amb_meas_i.value > high_thr;
	endsequence

	AST_PARAM_HOLD: assert property (seq_running |-> $stable(amb_param_o))
		else $error("ambient parameter changed while self-timed ran");
	AST_AMB_LATCH: assert property (amb_meas_i.valid |=>
		amb_result[15:8] == $past(amb_meas_i.value[15:8]))
		else $error("ambient high byte not captured");
	AST_RESULT_RO: assert property (wr.strobe && !amb_meas_i.valid
		&& wr.addr == `SLR_ADDR_AMB_LOW |=> $stable(amb_result))
		else $error("ambient result changed by a write");
	AST_BIO_LATCH: assert property (bio_meas_i.valid |=>
		bio_result[7:0] == $past(bio_meas_i.value[7:0]))
		else $error("biosensor low byte not captured");
	AST_CTRL_WRITE: assert property (wr.strobe
		&& wr.addr == `SLR_ADDR_IRQ_CTRL |=> ctrl == $past(wr.data))
		else $error("control write lost");
	AST_COUNT_ONE: assert property (seq_bio_hit_one |=> status[0])
		else $error("single biosensor hit did not flag");
	AST_SRC_AMB: assert property (seq_amb_hit_one |=> status[0])
		else $error("ambient source hit did not flag");
	AST_COUNT_TWO: assert property (ctrl[7:5] == 3'b001 && !status[0]
		&& above_cnt == 8'h00 && limit_ev && above && status_clr == 4'h0
		|=> !status[0])
		else $error("threshold fired before two hits");
	AST_BIO_GATED: assert property (!status[3] && !ctrl[3]
		|=> !status[3])
		else $error("disabled biosensor ready set its flag");
	AST_STICKY: assert property (status[0] && !status_clr[0]
		|=> status[0] ##1 irq_pad_oe_o)
		else $error("flag dropped or pad not driven");
	AST_THR_WRITE: assert property (wr.strobe
		&& wr.addr == `SLR_ADDR_LOW_THR_LO |=> low_thr[7:0] == $past(wr.data))
		else $error("low threshold write lost");

endmodule : slr_sensor_regs

// ### tb/slr_host.sv
`timescale 1ns/100ps
// ****
// Bus host model, open drain: 0 pulls low, 1 releases
// ****
module slr_host #(
	parameter logic [6:0] DEV = 7'h2A
) (
	// Clock and wire level
	input  wire logic clk_i,
	input  wire logic sda_i,
	// Driven levels
	output logic      scl_o,
	output logic      sda_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	// Data only moves while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_o = b;
		tick(2);
		scl_o = 1'b1;
		tick(3);
		r = sda_i;
		scl_o = 1'b0;
		tick(1);
	endtask : bit_io
	task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
	endtask : byte_io
	task automatic send(input logic [7:0] d, output logic a);
		logic [7:0] q;
		byte_io(d, q);
		bit_io(1'b1, a);
	endtask : send
	task automatic start();
		sda_o = 1'b1;
		tick(2);
		scl_o = 1'b1;
		tick(3);
		sda_o = 1'b0;
		tick(3);
		scl_o = 1'b0;
		tick(2);
	endtask : start
	task automatic stop();
		sda_o = 1'b0;
		tick(2);
		scl_o = 1'b1;
		tick(3);
		sda_o = 1'b1;
		tick(3);
	endtask : stop
	task automatic wr(input logic [7:0] ad, d, output logic nak);
		logic a0, a1, a2;
		start();
		send({DEV, 1'b0}, a0);
		send(ad, a1);
		send(d, a2);
		stop();
		nak = a0 | a1 | a2;
	endtask : wr
	// Repeated start keeps the pointer just set
	task automatic rd(input logic [7:0] ad, output logic [7:0] q,
		output logic nak);
		logic a0, a1, a2, x;
		start();
		send({DEV, 1'b0}, a0);
		send(ad, a1);
		start();
		send({DEV, 1'b1}, a2);
		byte_io(8'hFF, q);
		bit_io(1'b1, x);
		stop();
		nak = a0 | a1 | a2;
	endtask : rd
endmodule : slr_host

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic                  clk_i;
	logic                  arst_n_i;
	logic                  self_timed_en_i;
	logic                  scl;
	logic                  sda_h;
	logic                  sda_o;
	logic                  sda_oe_o;
	logic                  irq_pad_o;
	logic                  irq_pad_oe_o;
	logic [7:0]            amb_param_o;
	slr_pkg::slr_meas_type amb_meas_i;
	slr_pkg::slr_meas_type bio_meas_i;
	wire logic             sda;
	int                    n_errors;
	int                    checked;
	// Pull-up on the data wire
	assign sda = sda_h & (sda_oe_o ? sda_o : 1'b1);
	slr_sensor_regs #(.DEV_ADDR(7'h2A)) i_dut (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .amb_meas_i(amb_meas_i),
		.bio_meas_i(bio_meas_i), .self_timed_en_i(self_timed_en_i),
		.amb_param_o(amb_param_o), .irq_pad_o(irq_pad_o),
		.irq_pad_oe_o(irq_pad_oe_o));
	slr_host #(.DEV(7'h2A)) i_host (
		.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_h));
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic test_done();
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [8:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, d);
		logic k;
		i_host.wr(a, d, k);
		chk("ack", {8'h00, k}, 9'h000);
	endtask : wr
	// Top bit carries the ack level, which must be low
	task automatic rc(input string nm, input logic [7:0] a, exp);
		logic [7:0] q;
		logic       k;
		i_host.rd(a, q, k);
		chk(nm, {k, q}, {1'b0, exp});
	endtask : rc
	// A gap cycle keeps valid from being set and cleared in one step
	task automatic pulse(input logic bio, input logic [15:0] v);
		if (bio)
			bio_meas_i = {1'b1, v};
		else
			amb_meas_i = {1'b1, v};
		cyc(1);
		bio_meas_i.valid = 1'b0;
		amb_meas_i.valid = 1'b0;
		cyc(1);
	endtask : pulse
	task automatic t_reset();
		chk("param", amb_param_o, 8'h0D);
		chk("pad", irq_pad_oe_o, 1'b0);
		chk("pad lvl", irq_pad_o, 1'b0);
		rc("ctrl", 8'h89, 8'h00);
		rc("stat", 8'h8E, 8'h00);
	endtask : t_reset
	task automatic t_results();
		pulse(1'b0, 16'hA55A);
		pulse(1'b1, 16'h3CC3);
		wr(8'h85, 8'hFF);
		wr(8'h86, 8'h00);
		wr(8'h88, 8'h00);
		rc("amb hi", 8'h85, 8'hA5);
		rc("amb lo", 8'h86, 8'h5A);
		rc("bio hi", 8'h87, 8'h3C);
		rc("bio lo", 8'h88, 8'hC3);
		chk("quiet", irq_pad_oe_o, 1'b0);
		wr(8'h89, 8'hFF);
		rc("ctrl rw", 8'h89, 8'hEF);
	endtask : t_results
	task automatic t_ready();
		wr(8'h89, 8'h0C);
		pulse(1'b1, 16'h0001);
		cyc(1);
		chk("pad on", irq_pad_oe_o, 1'b1);
		rc("bio rdy", 8'h8E, 8'h08);
		pulse(1'b0, 16'h0002);
		rc("both", 8'h8E, 8'h0C);
		wr(8'h8E, 8'h08);
		rc("sticky", 8'h8E, 8'h04);
		wr(8'h8E, 8'h04);
		cyc(2);
		chk("pad off", irq_pad_oe_o, 1'b0);
	endtask : t_ready
	task automatic t_limit();
		wr(8'h8A, 8'h01);
		wr(8'h8B, 8'h20);
		wr(8'h8C, 8'h80);
		wr(8'h8D, 8'h34);
		rc("low lo", 8'h8B, 8'h20);
		rc("high hi", 8'h8C, 8'h80);
		wr(8'h89, 8'h02);
		pulse(1'b0, 16'h9000);
		cyc(1);
		chk("amb skip", irq_pad_oe_o, 1'b0);
		pulse(1'b1, 16'h8035);
		rc("above", 8'h8E, 8'h01);
		wr(8'h8E, 8'h01);
		wr(8'h89, 8'h03);
		pulse(1'b1, 16'h0000);
		rc("bio skip", 8'h8E, 8'h00);
		pulse(1'b0, 16'h011F);
		rc("below", 8'h8E, 8'h02);
		wr(8'h8E, 8'h02);
	endtask : t_limit
	task automatic t_count();
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h89, {c[2:0], 5'h02});
			repeat ((1 << c) - 1) pulse(1'b1, 16'hFFFF);
			cyc(1);
			chk("early", irq_pad_oe_o, 1'b0);
			pulse(1'b1, 16'hFFFF);
			cyc(1);
			chk("fire", irq_pad_oe_o, 1'b1);
			wr(8'h8E, 8'h0F);
		end
	endtask : t_count
	task automatic t_param();
		self_timed_en_i = 1'b1;
		cyc(2);
		wr(8'h84, 8'h55);
		chk("held", amb_param_o, 8'h0D);
		self_timed_en_i = 1'b0;
		cyc(2);
		self_timed_en_i = 1'b1;
		cyc(2);
		chk("cycled", amb_param_o, 8'h55);
	endtask : t_param
	initial
	begin
		n_errors = 0;
		checked = 0;
		arst_n_i = 1'b0;
		self_timed_en_i = 1'b0;
		amb_meas_i = '0;
		bio_meas_i = '0;
		repeat (10) @(posedge clk_i);
		#1 arst_n_i = 1'b1;
		cyc(3);
		t_reset();
		t_results();
		t_ready();
		t_limit();
		t_count();
		t_param();
		test_done();
	end
	// Hang guard
	initial
	begin
		repeat (100000) @(posedge clk_i);
		n_errors++;
		test_done();
	end
endmodule : tb_top
